/* beat_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes the same clock and reset as its user.
`timescale 1ns/1ps
module beat_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 4
)(
   input  wire logic         i_clock,
   input  wire logic         i_reset_n,
   input  wire logic         i_in_valid,
   output logic              o_in_ready,
   input  wire logic [W-1:0] i_in_data,
   output logic              o_out_valid,
   input  wire logic         i_out_ready,
   output logic [W-1:0]      o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0]  mem_q [DEPTH];   // Storage flops
   logic [AW-1:0] wp_q, wp_d;      // Write index
   logic [AW-1:0] rp_q, rp_d;      // Read index
   logic [AW:0]   cnt_q, cnt_d;    // Fill level
   logic          push, pop;
   // ---------------------------------------------------------------
   // Flags and pointers
   // ---------------------------------------------------------------
   always_comb
   begin
      o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
      o_out_valid = (cnt_q != '0);
      o_out_data  = mem_q[rp_q];
      push        = i_in_valid && o_in_ready;
      pop         = o_out_valid && i_out_ready;
      // Pointers wrap at the depth, which need not be a power of two
      wp_d  = push ? ((wp_q == AW'(DEPTH-1)) ? '0 : AW'(wp_q + 1'b1)) : wp_q;
      rp_d  = pop ? ((rp_q == AW'(DEPTH-1)) ? '0 : AW'(rp_q + 1'b1)) : rp_q;
      cnt_d = (AW+1)'(cnt_q + push - pop);
   end
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         wp_q  <= wp_d;
         rp_q  <= rp_d;
         cnt_q <= cnt_d;
      end
   end
   // Storage needs no reset; empty flag hides stale words
   always_ff @(posedge i_clock)
   begin
      if (push)
         mem_q[wp_q] <= i_in_data;
   end
endmodule

/* ddr_ctrl_model.sv */
// Memory controller model: link clock, clock enable and command pins.
// Assumes the block samples all of these asynchronously.
`timescale 1ns/1ps
module ddr_ctrl_model
   import sdram_mr_pkg::*;
(
   output logic      o_ck,
   output logic      o_cke,
   output cmd_pins_t o_cmd
);
   logic [MR_W-1:0] shadow_q [MR_CNT]; // Copy of every register
   logic            odt;               // Termination request, never raised
   // ---------------------------------------------------------------
   // Link clock, free running, phase unrelated to the system clock
   // ---------------------------------------------------------------
   initial
   begin
      o_ck = 1'b0;
      o_cke = 1'b0;
      o_cmd = '1;
      // Termination stays off, so writes need no ODT sequencing
      odt = 1'b0;
      #37;
      forever #100 o_ck = ~o_ck;
   end
   // ---------------------------------------------------------------
   // Command tasks
   // ---------------------------------------------------------------
   // One command for one ck cycle, set up at the falling edge
   task automatic drive(input cmd_pins_t c);
      cmd_pins_t idle;
      idle = ~c;
      idle.cs_n = 1'b1; // Deselected pins never show the last value
      @(negedge o_ck);
      o_cmd <= c;
      @(negedge o_ck);
      o_cmd <= idle;
   endtask
   task automatic wait_ck(input int n);
      repeat (n) @(posedge o_ck);
   endtask
   // Full register write, top bank bit low, then tMRD spacing
   task automatic mrs(input logic [1:0] sel, input logic [MR_W-1:0] val);
      shadow_q[sel] = val;
      drive(cmd_pins_t'{1'b0, 1'b0, 1'b0, 1'b0, {1'b0, sel}, val});
      wait_ck(TMRD_CK);
   endtask
   // Partial change issued as a complete register write
   task automatic mrs_field(input logic [MR_W-1:0] mask, input logic [MR_W-1:0] val);
      mrs(2'h0, (shadow_q[0] & ~mask) | val);
   endtask
   task automatic rw(input logic wr, input logic [MR_W-1:0] addr);
      drive(cmd_pins_t'{1'b0, 1'b1, 1'b0, ~wr, 3'h0, addr});
   endtask
   // CKE high, then every register written before use
   task automatic power_up;
      wait_ck(5);
      @(negedge o_ck);
      o_cke <= 1'b1;
      wait_ck(5);
      for (int i = MR_CNT - 1; i >= 0; i--)
         mrs(2'(i), 13'h0000);
   endtask
endmodule

/* sdram_mode_register_burst.sv */
// Mode register capture and burst beat ordering of the memory device.
// Assumes command pins and the link clock arrive asynchronously;
// a consumer drains beats through o_beat/i_beat_ready.
`timescale 1ns/1ps
// Function
// - four registers change only on mode set or DLL clear
// - mode set never touches array contents
// - features settle in tMOD; others wait
// - all-low command and bank selects register
// - A3 picks sequential or interleaved order
// - A1:A0 pick chop, burst or on-the-fly
// - burst-8 reads ordered from starting column
// - chop-4 reads float last four slots
// - writes ignore low column bits
// - fixed chop writes start two clocks early
// - DLL reset bit clears after reset done
module sdram_mode_register_burst #(
   parameter int TMOD_CK    = sdram_mr_pkg::TMOD_CK,
   parameter int FIFO_DEPTH = 4
)(
   input  wire logic                    i_clock,
   input  wire logic                    i_reset_n,
   input  wire logic                    i_ck,
   input  wire logic                    i_cke,
   input  wire sdram_mr_pkg::cmd_pins_t i_cmd,
   input  wire logic                    i_beat_ready,
   output logic [sdram_mr_pkg::MR_W-1:0] o_burst_latency,
   output logic                         o_mode_busy,
   output logic                         o_dll_reset,
   output logic                         o_wr_pull_in,
   output logic                         o_cmd_refused,
   output logic                         o_beat_valid,
   output sdram_mr_pkg::beat_t          o_beat
);
   import sdram_mr_pkg::*;
   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   cmd_pins_t cmd_s1_q, cmd_s2_q;   // Two stages for command pins
   logic      ck_s1_q, ck_s2_q;     // Two stages for the link clock
   logic      cke_s1_q, cke_s2_q;   // Two stages for clock enable
   logic      ck_old_q;             // Previous synced clock level
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         cmd_s1_q <= '1;
         cmd_s2_q <= '1;
         ck_s1_q  <= 1'b0;
         ck_s2_q  <= 1'b0;
         cke_s1_q <= 1'b0;
         cke_s2_q <= 1'b0;
         ck_old_q <= 1'b0;
      end
      else
      begin
         cmd_s1_q <= i_cmd;
         cmd_s2_q <= cmd_s1_q;
         ck_s1_q  <= i_ck;
         ck_s2_q  <= ck_s1_q;
         cke_s1_q <= i_cke;
         cke_s2_q <= cke_s1_q;
         ck_old_q <= ck_s2_q;
      end
   end
   // ---------------------------------------------------------------
   // Command decode on rising link clock edges
   // ---------------------------------------------------------------
   // Pins are sampled two cycles late like the clock, so they line up
   logic ck_rise, is_mrs, is_rw, is_wr;
   always_comb
   begin
      ck_rise = ck_s2_q && !ck_old_q && cke_s2_q;
      is_mrs  = ck_rise && !cmd_s2_q.cs_n && !cmd_s2_q.ras_n && !cmd_s2_q.cas_n && !cmd_s2_q.we_n;
      is_rw   = ck_rise && !cmd_s2_q.cs_n && cmd_s2_q.ras_n && !cmd_s2_q.cas_n;
      is_wr   = !cmd_s2_q.we_n;
   end
   // ---------------------------------------------------------------
   // Mode registers, settle counter, DLL reset
   // ---------------------------------------------------------------
   logic [MR_W-1:0]  mr_q [MR_CNT];  // Write-only mode registers
   logic [MR_W-1:0]  mr_d [MR_CNT];
   logic [CNT_W-1:0] mod_q, mod_d;   // Link edges left until settled
   logic             dll_q, dll_d;   // DLL reset pending
   logic             dllp_d;         // DLL reset pulse next
   always_comb
   begin
      mr_d   = mr_q;
      mod_d  = mod_q;
      dll_d  = dll_q;
      dllp_d = 1'b0;
      if (ck_rise && mod_q != '0)
         mod_d = CNT_W'(mod_q - 1'b1);
      // DLL reset is carried out one link edge after the write
      if (ck_rise && dll_q)
      begin
         dllp_d             = 1'b1;
         dll_d              = 1'b0;
         mr_d[0][DLL_BIT]   = 1'b0;
      end
      // Set after clear: a fresh write in the same edge wins
      // Top bank bit high selects no register and is ignored
      if (is_mrs && !cmd_s2_q.ba[2])
      begin
         mr_d[cmd_s2_q.ba[1:0]] = cmd_s2_q.addr;
         mod_d = CNT_W'(TMOD_CK);
         if (cmd_s2_q.ba[1:0] == BLR_SEL)
            dll_d = cmd_s2_q.addr[DLL_BIT];
      end
   end
   // Only register storage is touched; there is no path to the array
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         for (int i = 0; i < MR_CNT; i++)
            mr_q[i] <= MR_RESET;
         mod_q       <= '0;
         dll_q       <= 1'b0;
         o_dll_reset <= 1'b0;
         o_mode_busy <= 1'b0;
      end
      else
      begin
         mr_q        <= mr_d;
         mod_q       <= mod_d;
         dll_q       <= dll_d;
         o_dll_reset <= dllp_d;
         o_mode_busy <= (mod_d != '0);
      end
   end
   assign o_burst_latency = mr_q[0];
   // ---------------------------------------------------------------
   // Beat generator
   // ---------------------------------------------------------------
   typedef enum logic {GEN_IDLE, GEN_RUN} gen_t;
   gen_t       st_q, st_d;        // Generator state
   logic [2:0] idx_q, idx_d;      // Beat slot index
   logic [2:0] start_q, start_d;  // Starting column
   logic       wr_q, wr_d;        // Write burst
   logic       chop_q, chop_d;    // Chop-4 burst
   logic       int_q, int_d;      // Interleaved order
   logic       pull_d, ref_d;
   beat_t      push_beat;
   logic       push_ok;           // FIFO accepts a beat
   logic [1:0] bl;
   always_comb
   begin
      st_d    = st_q;
      idx_d   = idx_q;
      start_d = start_q;
      wr_d    = wr_q;
      chop_d  = chop_q;
      int_d   = int_q;
      pull_d  = o_wr_pull_in;
      ref_d   = 1'b0;
      bl      = mr_q[0][BL_LSB+1:BL_LSB];
      push_beat.col  = beat_col(start_q, idx_q, int_q, wr_q, chop_q);
      push_beat.hiz  = !wr_q && chop_q && idx_q[2];
      push_beat.dc   = wr_q && chop_q && idx_q[2];
      push_beat.wr   = wr_q;
      push_beat.last = (idx_q == 3'h7);
      case (st_q)
         GEN_IDLE:
         begin
            // Column access while settling is refused
            if (is_rw && o_mode_busy)
               ref_d = 1'b1;
            else if (is_rw)
            begin
               st_d    = GEN_RUN;
               idx_d   = 3'h0;
               start_d = cmd_s2_q.addr[2:0];
               wr_d    = is_wr;
               int_d   = mr_q[0][BT_BIT];
               chop_d  = (bl == BL_FIX4) ||
                         (bl == BL_OTF && !cmd_s2_q.addr[OTF_BIT]);
               // Early internal write only for fixed chop
               pull_d  = is_wr && (bl == BL_FIX4);
            end
         end
         GEN_RUN:
         begin
            // Column commands overlapping a running burst are dropped
            if (is_rw)
               ref_d = 1'b1;
            if (push_ok)
            begin
               idx_d = 3'(idx_q + 1'b1);
               if (idx_q == 3'h7)
                  st_d = GEN_IDLE;
            end
         end
         default:
            st_d = GEN_IDLE;
      endcase
   end
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         st_q          <= GEN_IDLE;
         idx_q         <= 3'h0;
         start_q       <= 3'h0;
         wr_q          <= 1'b0;
         chop_q        <= 1'b0;
         int_q         <= 1'b0;
         o_wr_pull_in  <= 1'b0;
         o_cmd_refused <= 1'b0;
      end
      else
      begin
         st_q          <= st_d;
         idx_q         <= idx_d;
         start_q       <= start_d;
         wr_q          <= wr_d;
         chop_q        <= chop_d;
         int_q         <= int_d;
         o_wr_pull_in  <= pull_d;
         o_cmd_refused <= ref_d;
      end
   end
   // ---------------------------------------------------------------
   // Beat buffer and registered output
   // ---------------------------------------------------------------
   // A stalled consumer fills the FIFO and then holds the generator
   logic  f_valid, pop;
   beat_t f_beat, ob_d;
   logic  ov_d;
   beat_fifo #(.W($bits(beat_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_clock     (i_clock),
      .i_reset_n   (i_reset_n),
      .i_in_valid  (st_q == GEN_RUN),
      .o_in_ready  (push_ok),
      .i_in_data   (push_beat),
      .o_out_valid (f_valid),
      .i_out_ready (pop),
      .o_out_data  (f_beat)
   );
   always_comb
   begin
      pop  = f_valid && (!o_beat_valid || i_beat_ready);
      ov_d = pop ? 1'b1 : (i_beat_ready ? 1'b0 : o_beat_valid);
      ob_d = pop ? f_beat : o_beat;
   end
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         o_beat_valid <= 1'b0;
         o_beat       <= '0;
      end
      else
      begin
         o_beat_valid <= ov_d;
         o_beat       <= ob_d;
      end
   end
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);
   logic run_chop;
   assign run_chop = (st_q == GEN_RUN) && push_ok;
   a_mr_stable: assert property (!is_mrs && !(ck_rise && dll_q) |=> $stable(o_burst_latency))
      else $error("mode register changed without a write");
   a_blr_load: assert property (is_mrs && cmd_s2_q.ba == 3'h0 |=> o_burst_latency == $past(cmd_s2_q.addr))
      else $error("register zero not loaded");
   a_settle_busy: assert property (is_mrs && !cmd_s2_q.ba[2] |=> o_mode_busy [*2])
      else $error("busy not raised after write");
   a_dll_clear: assert property (o_dll_reset |-> !o_burst_latency[DLL_BIT] && $past(dll_q))
      else $error("DLL reset bit not cleared");
   // Upper slots float; lower slots stay inside the starting group
   a_chop_float: assert property (run_chop && !wr_q && chop_q
      |-> push_beat.hiz == idx_q[2] && (idx_q[2] || push_beat.col[2] == start_q[2]))
      else $error("chop read slot not floated");
   a_write_order: assert property (run_chop && wr_q && !chop_q |-> push_beat.col == idx_q)
      else $error("burst write order wrong");
   a_inter_order: assert property (run_chop && !wr_q && int_q |-> push_beat.col == (start_q ^ idx_q))
      else $error("interleaved order wrong");
   a_pull_in: assert property (is_rw && is_wr && !o_mode_busy && st_q == GEN_IDLE
      && mr_q[0][1:0] == BL_FIX4 |=> o_wr_pull_in)
      else $error("fixed chop write not pulled in");
   a_otf_chop: assert property (is_rw && !o_mode_busy && st_q == GEN_IDLE && mr_q[0][1:0] == BL_OTF
      |=> chop_q == !$past(cmd_s2_q.addr[OTF_BIT]))
      else $error("on-the-fly length wrong");
   c_mode_write: cover property (is_mrs);
   c_read_burst: cover property (is_rw && !is_wr && st_q == GEN_IDLE && !o_mode_busy);
   c_stall: cover property (st_q == GEN_RUN && !push_ok);
   c_refused: cover property (o_cmd_refused);
endmodule

/* sdram_mr_pkg.sv */
// Constants, field layout and carrier types for the mode register block.
// Assumes a single system clock; pins arrive from the link domain.
package sdram_mr_pkg;
   // ---------------------------------------------------------------
   // Widths and counts
   // ---------------------------------------------------------------
   localparam int MR_W    = 13;  // Address pins A0..A12
   localparam int BA_W    = 3;   // Bank address pins
   localparam int MR_CNT  = 4;   // Mode registers held
   localparam int BEATS   = 8;   // Beat slots per burst
   localparam int TMRD_CK = 4;   // Command cycles between two writes
   localparam int TMOD_CK = 12;  // Command cycles until features settle
   localparam int CNT_W   = 8;   // Width of the settle counter
   // ---------------------------------------------------------------
   // Burst and latency register fields
   // ---------------------------------------------------------------
   localparam int BL_LSB   = 0;  // Burst length, two bits
   localparam int BT_BIT   = 3;  // Burst type
   localparam int DLL_BIT  = 8;  // DLL reset, self clearing
   localparam int OTF_BIT  = 12; // A12 on read/write: high = burst 8
   localparam logic [1:0] BL_FIX8 = 2'h0;
   localparam logic [1:0] BL_OTF  = 2'h1;
   localparam logic [1:0] BL_FIX4 = 2'h2;
   localparam logic [MR_W-1:0] MR_RESET = 13'h0000;
   localparam logic [1:0] BLR_SEL = 2'h0;  // Bank select of the burst and latency register
   // ---------------------------------------------------------------
   // Carrier types
   // ---------------------------------------------------------------
   typedef struct packed
   {
      logic            cs_n;
      logic            ras_n;
      logic            cas_n;
      logic            we_n;
      logic [BA_W-1:0] ba;
      logic [MR_W-1:0] addr;
   } cmd_pins_t;
   typedef struct packed
   {
      logic [2:0] col;  // Column of this beat
      logic       hiz;  // Drivers released in this slot
      logic       dc;   // Write slot ignored
      logic       wr;   // Beat belongs to a write
      logic       last; // Final slot of the burst
   } beat_t;
   // ---------------------------------------------------------------
   // Beat ordering
   // ---------------------------------------------------------------
   function automatic logic [2:0] beat_col(input logic [2:0] start, input logic [2:0] idx,
                                           input logic inter, input logic wr, input logic chop);
      logic [1:0] lo;
      lo = inter ? (start[1:0] ^ idx[1:0]) : 2'(start[1:0] + idx[1:0]);
      if (wr)
         beat_col = chop ? {start[2], idx[1:0]} : idx;
      else
         beat_col = {start[2] ^ idx[2], lo};
   endfunction
endpackage

/* tb.sv */
// Self-checking bench for the mode register and burst ordering block.
// Assumes the controller model drives all command pins.
`timescale 1ns/1ps
module tb;
   import sdram_mr_pkg::*;
   localparam int TMOD = 6; // Shortened settle count
   logic            i_clock, i_reset_n, i_beat_ready, ck, cke;
   cmd_pins_t       cmd;
   logic [MR_W-1:0] burst_latency;
   logic            mode_busy, dll_reset, wr_pull_in, cmd_refused, beat_valid;
   beat_t           beat;
   beat_t           got [BEATS];  // Beats taken from the block
   int              n_mismatch, total_checks, cycles;
   int              n_ref, n_dll, n_val; // Pulses and valid cycles since reset
   int              m_ref, m_dll, m_val; // Counts at the last mark
   sdram_mode_register_burst #(.TMOD_CK(TMOD), .FIFO_DEPTH(4)) dut_u (
      .i_clock(i_clock), .i_reset_n(i_reset_n), .i_ck(ck), .i_cke(cke), .i_cmd(cmd),
      .i_beat_ready(i_beat_ready), .o_burst_latency(burst_latency), .o_mode_busy(mode_busy),
      .o_dll_reset(dll_reset), .o_wr_pull_in(wr_pull_in), .o_cmd_refused(cmd_refused),
      .o_beat_valid(beat_valid), .o_beat(beat));
   ddr_ctrl_model ctrl_u (.o_ck(ck), .o_cke(cke), .o_cmd(cmd));
   // ---------------------------------------------------------------
   // Clock, timeout and shared tasks
   // ---------------------------------------------------------------
   always #12.5 i_clock = ~i_clock;
   // Ceiling well above the roughly 5k cycles the run needs
   always @(posedge i_clock)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         n_mismatch++;
         summarize;
      end
   end
   task automatic summarize;
      $display("Checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Pulses counted at the edge that ends them; a pulse that comes
   // before the command task returns is still seen
   always @(posedge i_clock)
   begin
      if (cmd_refused === 1'b1)
         n_ref++;
      if (dll_reset === 1'b1)
         n_dll++;
      if (beat_valid === 1'b1)
         n_val++;
   end
   // Notes the counts before a command is issued
   task automatic mark;
      m_ref = n_ref;
      m_dll = n_dll;
      m_val = n_val;
   endtask
   // Lets n cycles pass so that late pulses are counted
   task automatic watch(input int n);
      repeat (n) @(negedge i_clock);
   endtask
   // Takes eight beats; ready held low for the first stall cycles
   task automatic collect(input int stall);
      int n;
      int cyc;
      n = 0;
      cyc = 0;
      while (n < BEATS && cyc < 400)
      begin
         @(posedge i_clock);
         i_beat_ready <= (cyc >= stall);
         @(negedge i_clock);
         if (beat_valid === 1'b1 && i_beat_ready === 1'b1)
         begin
            got[n] = beat;
            n++;
         end
         cyc++;
      end
      @(posedge i_clock);
      i_beat_ready <= 1'b0;
      check("beat count", 16'(n), 16'(BEATS));
   endtask
   // Expected order worked out independently per slot
   task automatic judge(input logic wr, input logic bt, input logic chop, input logic [2:0] s);
      logic [2:0] i3;
      logic [1:0] lo;
      logic [2:0] col;
      logic       blank;
      for (int i = 0; i < BEATS; i++)
      begin
         i3 = 3'(i);
         lo = bt ? (s[1:0] ^ i3[1:0]) : 2'(s[1:0] + i3[1:0]);
         col = wr ? (chop ? {s[2], i3[1:0]} : i3) : {s[2] ^ i3[2], lo};
         blank = chop && (i >= 4);
         check("beat col", 16'(blank ? 3'h0 : got[i].col), 16'(blank ? 3'h0 : col));
         check("beat flags", 16'({got[i].hiz, got[i].dc, got[i].wr, got[i].last}),
               16'({!wr && blank, wr && blank, wr, i == 7}));
      end
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_reset;
      @(negedge i_clock);
      check("register after reset", 16'(burst_latency), 16'(MR_RESET));
      check("busy after reset", 16'(mode_busy), 16'h0000);
   endtask
   // Other registers and a reserved bank leave register 0 alone
   task automatic t_select;
      ctrl_u.wait_ck(TMOD + 2);
      ctrl_u.mrs(2'h1, 13'h1ABC);
      ctrl_u.drive(cmd_pins_t'{1'b0, 1'b0, 1'b0, 1'b0, 3'h4, 13'h1FFF});
      ctrl_u.wait_ck(2);
      check("register 0 untouched", 16'(burst_latency), 16'h0000);
      ctrl_u.mrs(2'h0, 13'h0A5C);
      check("register 0 written", 16'(burst_latency), 16'h0A5C);
      check("busy inside settle", 16'(mode_busy), 16'h0001);
      ctrl_u.wait_ck(3);
      watch(4);
      check("busy after settle", 16'(mode_busy), 16'h0000);
   endtask
   // Read issued before the settle time runs out is dropped
   task automatic t_refuse;
      ctrl_u.mrs(2'h0, 13'h0A5C);
      mark;
      ctrl_u.rw(1'b0, 13'h1000);
      watch(40);
      check("early read refused", 16'(n_ref - m_ref), 16'h0001);
      check("early read no beats", 16'(n_val - m_val), 16'h0000);
      ctrl_u.wait_ck(TMOD);
   endtask
   // DLL reset bit pulses once and reads back cleared
   task automatic t_dll;
      mark;
      ctrl_u.mrs_field(13'h0100, 13'h0100);
      watch(80);
      check("dll reset pulse", 16'(n_dll - m_dll), 16'h0001);
      check("dll bit cleared", 16'(burst_latency), 16'h0A5C);
      ctrl_u.shadow_q[0] = 13'h0A5C;
      ctrl_u.wait_ck(TMOD);
   endtask
   // Every burst type, length mode, start column and direction
   task automatic t_bursts;
      logic chop;
      logic a12;
      logic [1:0] bl [4];
      bl = '{BL_FIX8, BL_FIX4, BL_OTF, BL_OTF};
      for (int bt = 0; bt < 2; bt++)
         for (int m = 0; m < 4; m++)
         begin
            ctrl_u.mrs_field(13'h000B, {9'h000, 1'(bt), 1'b0, bl[m]});
            ctrl_u.wait_ck(TMOD);
            chop = (m == 1) || (m == 3);
            a12 = (m != 3);
            for (int s = 0; s < 8; s++)
               for (int wr = 0; wr < 2; wr++)
               begin
                  ctrl_u.rw(1'(wr), {a12, 9'h000, 3'(s)});
                  collect((s == 5) ? 12 : 0);
                  judge(1'(wr), 1'(bt), chop, 3'(s));
                  if (wr == 1)
                     check("write pull in", 16'(wr_pull_in), 16'(m == 1));
               end
         end
   endtask
   // Second read while the first is stalled behind a full buffer
   task automatic t_overlap;
      mark;
      ctrl_u.rw(1'b0, 13'h1003);
      ctrl_u.rw(1'b0, 13'h1006);
      watch(40);
      check("overlap refused", 16'(n_ref - m_ref), 16'h0001);
      collect(0);
      judge(1'b0, 1'b1, 1'b0, 3'h3);
      // Off the edge, so the last beat's count is already in
      watch(1);
      mark;
      watch(40);
      check("dropped read silent", 16'(n_val - m_val), 16'h0000);
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      i_clock = 1'b0;
      i_reset_n = 1'b0;
      i_beat_ready = 1'b0;
      n_mismatch = 0;
      total_checks = 0;
      cycles = 0;
      repeat (16) @(posedge i_clock);
      i_reset_n <= 1'b1;
      t_reset;
      ctrl_u.power_up;
      t_select;
      t_refuse;
      t_dll;
      t_bursts;
      t_overlap;
      summarize;
   end
endmodule
